// file: rtl/adcs_sequencer.v
// Successive-approximation conversion sequencer with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.vh"
module adcs_sequencer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        rc_clk_in,
    input  wire        cmp_in,
    input  wire [9:0]  pin_direction_bits,
    input  wire [9:0]  pin_level_in,
    input  wire        conversion_irq_enable,
    input  wire        peripheral_irq_enable,
    input  wire        global_irq_enable,
    output reg  [9:0]  analog_input_pins,
    output reg  [11:0] dac_code,
    output reg  [3:0]  mux_channel,
    output reg         sample_hold,
    output reg         converter_enable,
    output reg         done_irq,
    output reg  [9:0]  port_read_mask,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam ST_IDLE   = 3'b001;
    localparam ST_SETTLE = 3'b010;
    localparam ST_CONV   = 3'b100;

    reg  [7:0]  ctrl0_q;
    reg  [7:0]  ctrl1_q;
    reg  [7:0]  result_high_byte;
    reg  [7:0]  result_low_byte;
    reg         conversion_done_flag;
    reg  [2:0]  state_q;
    reg  [5:0]  div_q;
    reg         tad_tick_q;
    reg  [3:0]  bit_q;
    reg  [11:0] sar_q;
    reg  [2:0]  rc_sync_q;
    reg         rc_seen_q;
    reg  [31:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_have_q;
    reg         w_have_q;
    reg  [2:0]  cmp_sync_q;
    reg  [9:0]  pin_in_q1;
    reg  [9:0]  pin_in_q2;
    reg  [9:0]  pin_in_q3;

    wire [3:0]  port_analog_config = ctrl1_q[`ADCS_PCFG_MSB:`ADCS_PCFG_LSB];
    wire [2:0]  reference_select   = ctrl1_q[`ADCS_REFERENCE_SELECT_MSB:`ADCS_REFERENCE_SELECT_LSB];
    wire        result_justify_select = ctrl1_q[`ADCS_JUSTIFY_BIT];
    wire [1:0]  conv_clock_select  = ctrl0_q[`ADCS_CLKSEL_MSB:`ADCS_CLKSEL_LSB];
    wire [3:0]  channel_select = {ctrl0_q[`ADCS_CHS_HI_MSB:`ADCS_CHS_HI_LSB], ctrl0_q[`ADCS_CHS_LSB_BIT]};
    wire        converter_power_on = ctrl0_q[`ADCS_POWER_BIT];
    wire        go_q = ctrl0_q[`ADCS_GO_BIT];

    // Analog map from the port configuration code and reference overrides
    function [9:0] analog_map;
        input [3:0] cfg;
        input [2:0] vref;
        reg   [3:0] ndig;
        reg   [9:0] m;
        integer     i;
        begin
            ndig = (cfg >= `ADCS_PCFG_FIRST_D) ? (cfg - `ADCS_PCFG_FIRST_D + 4'd1) : 4'd0;
            for (i = 0; i < 10; i = i + 1) begin
                m[i] = (i < 10 - ndig);
            end
            if (vref == 3'd1 || vref == 3'd3) begin
                m[`ADCS_VREFP_PIN] = 1'b1;
            end
            if (vref == 3'd1 || vref == 3'd5) begin
                m[`ADCS_VREFN_PIN] = 1'b1;
            end
            analog_map = m;
        end
    endfunction

    wire [9:0]  amap = analog_map(port_analog_config, reference_select);
    wire        ch_valid = (channel_select < `ADCS_NUM_CH);
    wire        conv_busy = (state_q != ST_IDLE);
    wire        rc_rise = rc_sync_q[1] & rc_sync_q[2] & ~rc_seen_q;

    // Conversion-clock period ticks: oscillator divider or synchronised RC edge
    reg  [5:0]  div_lim;
    always @* begin
        case (conv_clock_select)
            2'b00:   div_lim = `ADCS_DIV_FOSC2;
            2'b01:   div_lim = `ADCS_DIV_FOSC8;
            2'b10:   div_lim = `ADCS_DIV_FOSC32;
            default: div_lim = `ADCS_DIV_FOSC2;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rc_sync_q <= 3'h0;
            rc_seen_q <= 1'b0;
            cmp_sync_q <= 3'h0;
            pin_in_q1 <= 10'h000;
            pin_in_q2 <= 10'h000;
            pin_in_q3 <= 10'h000;
        end else begin
            rc_sync_q <= {rc_sync_q[1:0], rc_clk_in};
            if (rc_sync_q[1] == rc_sync_q[2]) begin
                rc_seen_q <= rc_sync_q[2];
            end
            cmp_sync_q <= {cmp_sync_q[1:0], cmp_in};
            pin_in_q1 <= pin_level_in;
            pin_in_q2 <= pin_in_q1;
            pin_in_q3 <= pin_in_q2;
        end
    end

    // One oscillator period is one aclk; a 2-cycle period outruns the comparator synchroniser
    always @(posedge aclk) begin
        if (!aresetn || !conv_busy) begin
            div_q <= 6'h00;
            tad_tick_q <= 1'b0;
        end else if (conv_clock_select == 2'b11) begin
            div_q <= 6'h00;
            tad_tick_q <= rc_rise;
        end else if (div_q + 6'd1 >= div_lim) begin
            div_q <= 6'h00;
            tad_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 6'd1;
            tad_tick_q <= 1'b0;
        end
    end

    // Write decode and register update
    wire        wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire [7:0]  wbyte = wdata_q[7:0];
    wire        addr_ok_w = (awaddr_q[4:0] <= `ADCS_OFF_PINS) && (awaddr_q[1:0] == 2'b00) && (awaddr_q[31:5] == 27'h0);
    wire        wr_ctrl0 = wr_fire & addr_ok_w & wstrb_q[0] & (awaddr_q[4:0] == {1'b0, `ADCS_OFF_CTRL0});
    wire        wr_ctrl1 = wr_fire & addr_ok_w & wstrb_q[0] & (awaddr_q[4:0] == {1'b0, `ADCS_OFF_CTRL1});
    wire        wr_stat  = wr_fire & addr_ok_w & wstrb_q[0] & (awaddr_q[4:0] == `ADCS_OFF_STAT);
    // Sampled comparator decides the bit under trial; the driven pin level feeds it when output
    wire [3:0]  pin_idx = ch_valid ? channel_select : 4'd0;
    wire        pin_is_out = ch_valid & ~pin_direction_bits[pin_idx];
    wire        trial_keep = pin_is_out ? pin_in_q3[pin_idx] : cmp_sync_q[2];
    wire        last_bit = (bit_q == 4'd0);
    wire [11:0] final_val = ch_valid ? sar_q : 12'hfff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_q <= `ADCS_CTRL0_RST;
            ctrl1_q <= `ADCS_CTRL1_RST;
            conversion_done_flag <= 1'b0;
            state_q <= ST_IDLE;
            bit_q <= 4'd11;
            sar_q <= 12'h000;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_q <= wbyte;
                if (wbyte[`ADCS_POWER_BIT] & ~converter_power_on) begin
                    ctrl0_q[`ADCS_GO_BIT] <= 1'b0;
                end
            end
            if (wr_ctrl1) begin
                ctrl1_q <= wbyte;
            end
            if (wr_stat && wbyte[`ADCS_DONE_BIT]) begin
                conversion_done_flag <= 1'b0; // Write-one-to-clear
            end
            case (state_q)
                ST_IDLE: begin
                    if (go_q && converter_power_on && !wr_ctrl0) begin
                        state_q <= ST_SETTLE;
                        sar_q <= 12'h800;
                        bit_q <= 4'd11;
                    end
                end
                ST_SETTLE: begin
                    if (!go_q || !converter_power_on) begin
                        state_q <= ST_IDLE;
                        sar_q <= 12'h000;
                    end else if (tad_tick_q) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (!go_q || !converter_power_on) begin
                        state_q <= ST_IDLE;
                        {result_high_byte, result_low_byte} <= result_justify_select ?
                            {4'h0, final_val & (sar_q & ~(12'h800 >> (4'd11 - bit_q)))} :
                            {final_val & (sar_q & ~(12'h800 >> (4'd11 - bit_q))), 4'h0};
                    end else if (tad_tick_q) begin
                        sar_q[bit_q] <= trial_keep;
                        if (last_bit) begin
                            state_q <= ST_IDLE;
                            ctrl0_q[`ADCS_GO_BIT] <= 1'b0;
                            conversion_done_flag <= 1'b1;
                            {result_high_byte, result_low_byte} <= result_justify_select ?
                                {4'h0, ch_valid ? {sar_q[11:1], trial_keep} : 12'hfff} :
                                {ch_valid ? {sar_q[11:1], trial_keep} : 12'hfff, 4'h0};
                        end else begin
                            sar_q[bit_q - 4'd1] <= 1'b1;
                            bit_q <= bit_q - 4'd1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Pin-facing outputs registered; result bytes deliberately outside reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            analog_input_pins <= 10'h3ff;
            dac_code <= 12'h000;
            mux_channel <= 4'h0;
            sample_hold <= 1'b0;
            converter_enable <= 1'b0;
            done_irq <= 1'b0;
            port_read_mask <= 10'h000;
        end else begin
            analog_input_pins <= amap;
            port_read_mask <= amap;
            dac_code <= sar_q;
            mux_channel <= channel_select;
            sample_hold <= (state_q == ST_CONV) & go_q & converter_power_on;
            converter_enable <= converter_power_on;
            done_irq <= conversion_done_flag & conversion_irq_enable & peripheral_irq_enable & global_irq_enable;
        end
    end

    // AXI4-Lite slave: address and data taken in either order, one response each
    wire        rd_ok = (s_axi_araddr[4:0] <= `ADCS_OFF_PINS) && (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[31:5] == 27'h0);
    reg  [31:0] rd_mux;
    always @* begin
        case (s_axi_araddr[4:0])
            {1'b0, `ADCS_OFF_CTRL0}: rd_mux = {24'h0, ctrl0_q};
            {1'b0, `ADCS_OFF_CTRL1}: rd_mux = {24'h0, ctrl1_q};
            {1'b0, `ADCS_OFF_RESHI}: rd_mux = {24'h0, result_high_byte};
            {1'b0, `ADCS_OFF_RESLO}: rd_mux = {24'h0, result_low_byte};
            `ADCS_OFF_STAT:          rd_mux = {29'h0, conv_busy, ch_valid, conversion_done_flag};
            `ADCS_OFF_PINS:          rd_mux = {22'h0, amap};
            default:                 rd_mux = 32'h0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ADCS_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok_w ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_ok ? rd_mux : 32'h0;
                s_axi_rresp <= rd_ok ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // adcs_sequencer
`default_nettype wire

// file: rtl/adcs_regs.vh
// Register offsets, fields, reset values and timing counts of the conversion sequencer
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH
`define ADCS_OFF_CTRL0      4'h0
`define ADCS_OFF_CTRL1      4'h4
`define ADCS_OFF_RESHI      4'h8
`define ADCS_OFF_RESLO      4'hc
`define ADCS_OFF_STAT       5'h10
`define ADCS_OFF_PINS       5'h14
`define ADCS_CTRL0_RST      8'h00
`define ADCS_CTRL1_RST      8'h00
`define ADCS_POWER_BIT      0
`define ADCS_GO_BIT         2
`define ADCS_CHS_LSB_BIT    1
`define ADCS_CHS_HI_LSB     3
`define ADCS_CHS_HI_MSB     5
`define ADCS_CLKSEL_LSB     6
`define ADCS_CLKSEL_MSB     7
`define ADCS_PCFG_LSB       0
`define ADCS_PCFG_MSB       3
`define ADCS_REFERENCE_SELECT_LSB       4
`define ADCS_REFERENCE_SELECT_MSB       6
`define ADCS_JUSTIFY_BIT    7
`define ADCS_DONE_BIT       0
`define ADCS_DIV_FOSC2      6'd2
`define ADCS_DIV_FOSC8      6'd8
`define ADCS_DIV_FOSC32     6'd32
`define ADCS_PERIODS        4'd13
`define ADCS_NUM_CH         4'd10
`define ADCS_PCFG_FIRST_D   4'h6
`define ADCS_VREFP_PIN      3
`define ADCS_VREFN_PIN      2
`define ADCS_RESP_OKAY      2'b00
`define ADCS_RESP_SLVERR    2'b10
`endif

// file: verification/adcs_analog_model.sv
// Analog front end: per-channel levels on the comparator and a free-running RC clock
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model (
    input  wire logic        aclk,
    input  wire logic [11:0] dac_code,
    input  wire logic [3:0]  mux_channel,
    input  wire logic        sample_hold,
    output wire logic        cmp_in,
    output wire logic        rc_clk_in
);
    logic [5:0]  rc_cnt_q = 6'h00;
    logic        junk_q   = 1'b0;
    logic [11:0] level;
    // Channel n sits at n0f so a partial result shows as n00
    assign level = (mux_channel < 4'ha) ? {mux_channel, 8'h0f} : 12'h000;
    always @(posedge aclk) begin
        rc_cnt_q <= rc_cnt_q + 6'h01;
        junk_q   <= ~junk_q;
    end
    // Outside bit periods the comparator means nothing, so it toggles
    assign cmp_in    = sample_hold ? (level >= dac_code) : junk_q;
    // RC period of 64 cycles, 2.56 us; no sleep here, so RC runs awake
    assign rc_clk_in = rc_cnt_q[5];
endmodule // adcs_analog_model
`default_nettype wire

// file: verification/adcs_sequencer_chk.sv
// Sequencing and bus assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        conversion_irq_enable,
    input wire logic        peripheral_irq_enable,
    input wire logic        global_irq_enable,
    input wire logic [9:0]  analog_input_pins,
    input wire logic [11:0] dac_code,
    input wire logic        sample_hold,
    input wire logic        converter_enable,
    input wire logic        done_irq,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rst_idle: assert property ($rose(aresetn) |-> analog_input_pins == 10'h3ff && !sample_hold)
        else $error("outputs not idle after reset");
    a_hold_power: assert property (sample_hold |-> converter_enable)
        else $error("conversion running while powered off");
    a_irq_gate: assert property (done_irq |-> $past(conversion_irq_enable) &&
        $past(peripheral_irq_enable) && $past(global_irq_enable)) else $error("interrupt without enables");
    a_bit_min: assert property ($rose(sample_hold) |-> sample_hold[*8])
        else $error("bit phase too short");
    a_bit_end: assert property ($rose(sample_hold) |-> ##[12:800] $fell(sample_hold))
        else $error("bit phase length out of range");
    a_trial_clr: assert property ($rose(sample_hold) |-> dac_code[10:0] == 11'h000)
        else $error("stale bits in trial code");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    c_conv_end: cover property ($fell(sample_hold));
    c_irq: cover property ($rose(done_irq));
    c_masked: cover property (sample_hold && !global_irq_enable);
endmodule // adcs_sequencer_chk
bind adcs_sequencer adcs_sequencer_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .conversion_irq_enable(conversion_irq_enable),
    .peripheral_irq_enable(peripheral_irq_enable), .global_irq_enable(global_irq_enable),
    .analog_input_pins(analog_input_pins), .dac_code(dac_code), .sample_hold(sample_hold),
    .converter_enable(converter_enable), .done_irq(done_irq), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: verification/adcs_sequencer_tb.sv
// Register-level testbench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, irq_en = 1'b0, cmp, rc_clk, sh, ce, done_irq;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [9:0]  dir = 10'h3ff, lvl = 10'h000, pins, rmask;
    logic [11:0] dac;
    logic [3:0]  mux;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    integer      errors = 0, comparisons = 0;
    adcs_sequencer uut (
        .aclk(aclk), .aresetn(aresetn), .rc_clk_in(rc_clk), .cmp_in(cmp), .pin_direction_bits(dir),
        .pin_level_in(lvl), .conversion_irq_enable(irq_en), .peripheral_irq_enable(irq_en),
        .global_irq_enable(irq_en), .analog_input_pins(pins), .dac_code(dac), .mux_channel(mux),
        .sample_hold(sh), .converter_enable(ce), .done_irq(done_irq), .port_read_mask(rmask),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    adcs_analog_model fe (
        .aclk(aclk), .dac_code(dac), .mux_channel(mux), .sample_hold(sh), .cmp_in(cmp), .rc_clk_in(rc_clk));
    initial begin
        forever #20 aclk = ~aclk;
    end
    task results;
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    // Longest legal run is a few thousand cycles; this only cuts a hang
    initial begin
        #2000000;
        errors = errors + 1;
        results;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d, input [1:0] e);
        begin
            @(posedge aclk);
            awaddr <= {24'h0, a};
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, e});
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge aclk);
            araddr <= {24'h0, a};
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rready <= 1'b0;
            d = rdata;
            chk({30'h0, rresp}, {30'h0, (a > 8'h14) ? 2'b10 : 2'b00});
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        logic [31:0] d;
        begin
            rd(a, d);
            chk(d, {24'h0, e});
        end
    endtask
    task conv(input [1:0] cs, input [3:0] ch, input [3:0] cf, input j, input [11:0] r);
        logic [31:0] d;
        logic [7:0]  c;
        begin
            c = {cs, ch[3:1], 1'b0, ch[0], 1'b1};
            wr(8'h04, {j, 3'h0, cf}, 2'b00);
            wr(8'h00, c, 2'b00);
            repeat ((cs == 2'b11) ? 192 : 96) @(posedge aclk);
            wr(8'h00, c | 8'h04, 2'b00);
            do rd(8'h00, d); while (d[2]);
            chk({28'h0, mux}, {28'h0, ch});
            chk({31'h0, done_irq}, {31'h0, irq_en});
            rdc(8'h08, j ? {4'h0, r[11:8]} : r[11:4]);
            rdc(8'h0c, j ? r[7:0] : {r[3:0], 4'h0});
            rdc(8'h10, {6'h0, ch < 4'ha, 1'b1});
            wr(8'h10, 8'h01, 2'b00);
            rdc(8'h10, {6'h0, ch < 4'ha, 1'b0});
        end
    endtask
    initial begin : main
        integer      i;
        logic [9:0]  m;
        logic [31:0] d;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h00, 8'h00);
        wr(8'h00, 8'h05, 2'b00);
        rdc(8'h00, 8'h01);
        wr(8'h10, 8'h01, 2'b00);
        irq_en <= 1'b1;
        for (i = 0; i < 24; i = i + 1) begin
            m = (i < 6) ? 10'h3ff : (i < 16) ? 10'h3ff >> (i - 5) : 10'h000;
            if (i > 15) m = m | {6'h0, i == 17 || i == 19, i == 17 || i == 21, 2'b00};
            wr(8'h04, (i < 16) ? {4'h0, i[3:0]} : {1'b0, i[2:0], 4'hf}, 2'b00);
            rd(8'h14, d);
            chk(d, {22'h0, m});
            chk({22'h0, pins}, {22'h0, m});
            chk({22'h0, rmask}, {22'h0, m});
        end
        // Fastest divided source only where the result ignores the comparator
        conv(2'b10, 4'h1, 4'h0, 1'b0, 12'h10f);
        conv(2'b01, 4'h2, 4'h0, 1'b1, 12'h20f);
        conv(2'b10, 4'h8, 4'hf, 1'b0, 12'h80f);
        conv(2'b11, 4'h9, 4'h9, 1'b1, 12'h90f);
        irq_en <= 1'b0;
        conv(2'b00, 4'ha, 4'h0, 1'b1, 12'hfff);
        dir <= 10'h3fe;
        lvl <= 10'h001;
        conv(2'b00, 4'h0, 4'h0, 1'b0, 12'hfff);
        dir <= 10'h3ff;
        wr(8'h04, 8'h00, 2'b00);
        wr(8'h00, 8'h8b, 2'b00);
        repeat (96) @(posedge aclk);
        wr(8'h00, 8'h8f, 2'b00);
        while (!sh) @(posedge aclk);
        // Five 32-cycle bit periods pass before the abort lands; bits 7 down to 4 are 0
        repeat (160) @(posedge aclk);
        wr(8'h00, 8'h8b, 2'b00);
        rdc(8'h08, 8'h30);
        rdc(8'h0c, 8'h00);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h08, 8'h30);
        chk({31'h0, ce}, 32'h0);
        rdc(8'h00, 8'h00);
        rdc(8'h20, 8'h00);
        wr(8'h18, 8'h01, 2'b10);
        results;
    end
endmodule // adcs_sequencer_tb
`default_nettype wire
